// *** logic/pmx_map.svh ***
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

`define PMX_NUM_PADS       6
`define PMX_SEL_W          4
`define PMX_NUM_FUNC       16
`define PMX_CFG_W          8

// byte addresses
`define PMX_CTRL_ADDR      12'h000
`define PMX_STATUS_ADDR    12'h004
`define PMX_PAD_IN_ADDR    12'h008
`define PMX_PAD_CFG_BASE   12'h010

// pad config word fields
`define PMX_CFG_SEL_LSB    0
`define PMX_CFG_LP_LSB     4
`define PMX_CFG_DRV_BIT    6
`define PMX_CFG_ANA_BIT    7

// reset values
`define PMX_CFG_RESET      8'h00
`define PMX_CTRL_RESET     2'h0

// encodings 0..13 may carry a function, 14 and 15 never do
`define PMX_FUNC_VALID     16'h3FFF

// fixed pad roles
`define PMX_PAD_OSC_EN     0
`define PMX_PAD_RADIO_SW   1
`define PMX_PAD_SLOW_OSC   2
`define PMX_PAD_ANA_FIRST  3

// boot window in which the straps are sensed
`define PMX_BOOT_TIME_NS   10000
`define PMX_CLK_PERIOD_NS  100
`define PMX_BOOT_CYCLES    (`PMX_BOOT_TIME_NS / `PMX_CLK_PERIOD_NS)

`endif

// *** logic/pmx_pkg.sv ***
package pmx_pkg;

	typedef enum logic [1:0] {
		PMX_PWR_RUN,
		PMX_PWR_DEEP_SLEEP,
		PMX_PWR_HIB,
		PMX_PWR_RSVD
	} pmx_pwr_t;

	typedef enum logic [1:0] {
		PMX_LP_HIZ,
		PMX_LP_PULL_UP,
		PMX_LP_PULL_DOWN,
		PMX_LP_DRIVE
	} pmx_lp_t;

	typedef enum logic {
		PMX_BOOT_SENSE,
		PMX_BOOT_DONE
	} pmx_boot_t;

endpackage

// *** logic/pmx_cfg_mem.sv ***
`timescale 1ns/100ps
`include "pmx_map.svh"

module pmx_cfg_mem (
	input  wire logic                                        pclk,
	input  wire logic                                        presetn,
	input  wire logic                                        wr_en,
	input  wire logic [2:0]                                  wr_idx,
	input  wire logic [`PMX_CFG_W-1:0]                       wr_data,
	input  wire logic [2:0]                                  rd_idx,
	output logic      [`PMX_CFG_W-1:0]                       rd_data,
	output logic      [`PMX_NUM_PADS*`PMX_CFG_W-1:0]         all_words
);

	genvar g;
	generate
		for (g = 0; g < `PMX_NUM_PADS; g++) begin : g_word
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					all_words[g*`PMX_CFG_W +: `PMX_CFG_W] <= `PMX_CFG_RESET;
				else if (wr_en && wr_idx == 3'(g))
					all_words[g*`PMX_CFG_W +: `PMX_CFG_W] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data <= `PMX_CFG_RESET;
		else if (rd_idx < 3'(`PMX_NUM_PADS))
			rd_data <= all_words[rd_idx*`PMX_CFG_W +: `PMX_CFG_W];
		else
			rd_data <= `PMX_CFG_RESET;
	end

endmodule

// *** logic/pmx_top.sv ***
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "pmx_map.svh"

module pmx_top (
	input  wire logic                                        pclk,
	input  wire logic                                        presetn,
	input  wire logic                                        psel,
	input  wire logic                                        penable,
	input  wire logic                                        pwrite,
	input  wire logic [11:0]                                 paddr,
	input  wire logic [31:0]                                 pwdata,
	output logic      [31:0]                                 prdata,
	output logic                                             pready,
	output logic                                             pslverr,
	input  wire logic [`PMX_NUM_PADS*`PMX_NUM_FUNC-1:0]      func_out,
	input  wire logic [`PMX_NUM_PADS*`PMX_NUM_FUNC-1:0]      func_oe,
	output logic      [`PMX_NUM_PADS-1:0]                    func_in,
	input  wire logic                                        radio_sw_ctrl,
	input  wire logic [`PMX_NUM_PADS-1:0]                    pad_in,
	output logic      [`PMX_NUM_PADS-1:0]                    pad_out,
	output logic      [`PMX_NUM_PADS-1:0]                    pad_oe_n,
	output logic      [`PMX_NUM_PADS-1:0]                    pad_pull_up,
	output logic      [`PMX_NUM_PADS-1:0]                    pad_pull_down,
	output logic      [`PMX_NUM_PADS-1:0]                    pad_analog_en,
	output logic      [2:0]                                  boot_mode_strap,
	output logic                                             slow_clk_ext
);

	localparam int BOOT_CNT_W = $clog2(`PMX_BOOT_CYCLES + 1);
	localparam logic [BOOT_CNT_W-1:0] BOOT_LAST = BOOT_CNT_W'(`PMX_BOOT_CYCLES - 1);

	logic [`PMX_NUM_PADS-1:0]                 pad_meta;
	logic [`PMX_NUM_PADS-1:0]                 pad_sync;
	logic [`PMX_NUM_PADS*`PMX_CFG_W-1:0]      cfg_words;
	logic [`PMX_CFG_W-1:0]                    mem_rdata;
	logic                                     mem_wr;
	logic [2:0]                               pad_idx;
	logic                                     is_cfg;
	logic                                     is_mapped;
	logic                                     rd_wait;
	logic [1:0]                               ctrl;
	pmx_pkg::pmx_pwr_t                        pwr_mode;
	pmx_pkg::pmx_boot_t                       boot_state;
	logic [BOOT_CNT_W-1:0]                    boot_cnt;
	logic                                     boot_active;
	logic [`PMX_NUM_PADS-1:0]                 next_out;
	logic [`PMX_NUM_PADS-1:0]                 next_oe_n;
	logic [`PMX_NUM_PADS-1:0]                 next_pu;
	logic [`PMX_NUM_PADS-1:0]                 next_pd;
	logic [`PMX_NUM_PADS-1:0]                 next_ana;
	logic [`PMX_NUM_PADS-1:0]                 next_fin;

	// pins are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_meta <= '0;
			pad_sync <= '0;
		end else begin
			pad_meta <= pad_in;
			pad_sync <= pad_meta;
		end
	end

	// apb slave
	assign pad_idx   = 3'((paddr - `PMX_PAD_CFG_BASE) >> 2);
	assign is_cfg    = paddr >= `PMX_PAD_CFG_BASE && paddr[1:0] == 2'h0 && pad_idx < 3'(`PMX_NUM_PADS)
		&& paddr < 12'(`PMX_PAD_CFG_BASE + 4 * `PMX_NUM_PADS);
	assign is_mapped = is_cfg || paddr == `PMX_CTRL_ADDR || paddr == `PMX_STATUS_ADDR
		|| paddr == `PMX_PAD_IN_ADDR;
	assign mem_wr    = psel && penable && pready && pwrite && is_cfg;
	assign pwr_mode  = pmx_pkg::pmx_pwr_t'(ctrl);

	pmx_cfg_mem u_cfg_mem (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (mem_wr),
		.wr_idx    (pad_idx),
		.wr_data   (pwdata[`PMX_CFG_W-1:0]),
		.rd_idx    (pad_idx),
		.rd_data   (mem_rdata),
		.all_words (cfg_words)
	);

	// setup edge loads the config read register; the answer comes one access cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_wait <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && !penable) begin
			rd_wait <= 1'b1;
			pready  <= 1'b0;
		end else if (psel && penable && rd_wait) begin
			rd_wait <= 1'b0;
			pready  <= 1'b1;
			pslverr <= !is_mapped;
			prdata  <= 32'h00000000;
			if (!pwrite) begin
				if (is_cfg)
					prdata <= {24'h000000, mem_rdata};
				else if (paddr == `PMX_CTRL_ADDR)
					prdata <= {30'h00000000, ctrl};
				else if (paddr == `PMX_STATUS_ADDR)
					prdata <= {26'h0000000, boot_active == 1'b0, slow_clk_ext, 1'b0, boot_mode_strap};
				else if (paddr == `PMX_PAD_IN_ADDR)
					prdata <= {26'h0000000, pad_sync};
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= `PMX_CTRL_RESET;
		else if (psel && penable && pready && pwrite && paddr == `PMX_CTRL_ADDR)
			ctrl <= pwdata[1:0];
	end

	// boot: strap and slow-clock sensing
	assign boot_active = boot_state == pmx_pkg::PMX_BOOT_SENSE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_state      <= pmx_pkg::PMX_BOOT_SENSE;
			boot_cnt        <= '0;
			boot_mode_strap <= 3'h0;
			slow_clk_ext    <= 1'b0;
		end else begin
			case (boot_state)
				pmx_pkg::PMX_BOOT_SENSE: begin
					boot_cnt <= boot_cnt + 1'b1;
					if (boot_cnt == BOOT_LAST) begin
						boot_state         <= pmx_pkg::PMX_BOOT_DONE;
						boot_mode_strap[0] <= pad_sync[`PMX_PAD_RADIO_SW];
						boot_mode_strap[1] <= pad_sync[`PMX_PAD_ANA_FIRST];
						boot_mode_strap[2] <= pad_sync[`PMX_PAD_OSC_EN];
						slow_clk_ext       <= pad_sync[`PMX_PAD_SLOW_OSC];
					end
				end
				pmx_pkg::PMX_BOOT_DONE: boot_cnt <= boot_cnt;
				default: boot_state <= pmx_pkg::PMX_BOOT_SENSE;
			endcase
		end
	end

	// per-pad steering
	genvar g;
	generate
		for (g = 0; g < `PMX_NUM_PADS; g++) begin : g_pad
			logic [`PMX_CFG_W-1:0]      cfg;
			logic [`PMX_SEL_W-1:0]      sel;
			pmx_pkg::pmx_lp_t           lp;
			logic                       fvalid;
			logic                       is_ana;

			assign cfg    = cfg_words[g*`PMX_CFG_W +: `PMX_CFG_W];
			assign sel    = cfg[`PMX_CFG_SEL_LSB +: `PMX_SEL_W];
			assign lp     = pmx_pkg::pmx_lp_t'(cfg[`PMX_CFG_LP_LSB +: 2]);
			assign fvalid = 1'(`PMX_FUNC_VALID >> sel);
			assign is_ana = g >= `PMX_PAD_ANA_FIRST && cfg[`PMX_CFG_ANA_BIT];

			always_comb begin
				next_out[g]  = 1'b0;
				next_oe_n[g] = 1'b1;
				next_pu[g]   = 1'b0;
				next_pd[g]   = 1'b0;
				next_ana[g]  = 1'b0;
				next_fin[g]  = 1'b0;
				if (boot_active) begin
					next_oe_n[g] = 1'b1;
				end else if (pwr_mode == pmx_pkg::PMX_PWR_HIB && g == `PMX_PAD_OSC_EN) begin
					next_pd[g] = 1'b1;
				end else if (pwr_mode == pmx_pkg::PMX_PWR_DEEP_SLEEP || pwr_mode == pmx_pkg::PMX_PWR_HIB) begin
					// override ignores the function select on purpose
					case (lp)
						pmx_pkg::PMX_LP_PULL_UP:   next_pu[g] = 1'b1;
						pmx_pkg::PMX_LP_PULL_DOWN: next_pd[g] = 1'b1;
						pmx_pkg::PMX_LP_DRIVE: begin
							next_oe_n[g] = 1'b0;
							next_out[g]  = cfg[`PMX_CFG_DRV_BIT];
						end
						default: next_oe_n[g] = 1'b1;
					endcase
				end else if (g == `PMX_PAD_OSC_EN) begin
					next_oe_n[g] = 1'b0;
					next_out[g]  = 1'b1;
				end else if (g == `PMX_PAD_RADIO_SW) begin
					next_oe_n[g] = 1'b0;
					next_out[g]  = radio_sw_ctrl;
				end else if (g == `PMX_PAD_SLOW_OSC && !slow_clk_ext) begin
					next_oe_n[g] = 1'b1;
				end else if (is_ana) begin
					next_ana[g] = 1'b1;
				end else if (fvalid) begin
					// a freed slow-osc pad still follows the function; outputs only is advised
					next_oe_n[g] = !func_oe[g*`PMX_NUM_FUNC + int'(sel)];
					next_out[g]  = func_out[g*`PMX_NUM_FUNC + int'(sel)];
					next_fin[g]  = pad_sync[g];
				end
			end
		end
	endgenerate

	// registered pad drive; reset holds every pad in hi-z with no pull
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out       <= '0;
			pad_oe_n      <= '1;
			pad_pull_up   <= '0;
			pad_pull_down <= '0;
			pad_analog_en <= '0;
			func_in       <= '0;
		end else begin
			pad_out       <= next_out;
			pad_oe_n      <= next_oe_n;
			pad_pull_up   <= next_pu;
			pad_pull_down <= next_pd;
			pad_analog_en <= next_ana;
			func_in       <= next_fin;
		end
	end

endmodule

// *** test/pmx_chk.sv ***
`timescale 1ns/100ps
`include "pmx_map.svh"
module pmx_chk (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [11:0]              paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     radio_sw_ctrl,
	input wire logic [`PMX_NUM_PADS-1:0] pad_out,
	input wire logic [`PMX_NUM_PADS-1:0] pad_oe_n,
	input wire logic [`PMX_NUM_PADS-1:0] pad_pull_up,
	input wire logic [`PMX_NUM_PADS-1:0] pad_pull_down,
	input wire logic [`PMX_NUM_PADS-1:0] pad_analog_en,
	input wire logic [2:0]               boot_mode_strap,
	input wire logic                     slow_clk_ext
);
	logic [6:0] cyc;
	logic [1:0] mode;
	logic       done;
	logic       run;
	// edges since release; saturates so the boot window is never seen twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cyc <= 7'h00;
		else if (cyc != 7'h7F) cyc <= cyc + 7'h01;
	end
	// shadow of the power mode, taken at the completing edge like the slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) mode <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == `PMX_CTRL_ADDR) mode <= pwdata[1:0];
	end
	assign done = cyc > 7'h65;
	assign run  = mode == 2'h0 || mode == 2'h3;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_wait; psel && !penable |=> !pready ##1 pready; endproperty
	property p_rdy_one; pready |=> !pready; endproperty
	property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
	property p_boot_hiz; cyc < 7'h64 |-> &pad_oe_n && !(|pad_pull_up) && !(|pad_pull_down); endproperty
	property p_osc_run; done && run && $past(run) |-> !pad_oe_n[0] && pad_out[0]; endproperty
	property p_osc_hib; done && mode == 2'h2 && $past(mode) == 2'h2 |-> pad_oe_n[0] && pad_pull_down[0]; endproperty
	property p_radio; done && run && $past(run) |-> !pad_oe_n[1] && pad_out[1] == $past(radio_sw_ctrl); endproperty
	property p_strap_hold; done |-> $stable(boot_mode_strap) && $stable(slow_clk_ext); endproperty
	property p_ana_low; pad_analog_en[2:0] == 3'h0; endproperty
	property p_ana_hiz; (pad_analog_en & ~pad_oe_n) == 6'h00; endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready not on second edge");
	a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
	a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
	a_boot_hiz: assert property (p_boot_hiz) else $error("pad driven or pulled in boot window");
	a_osc_run: assert property (p_osc_run) else $error("oscillator enable not driven high");
	a_osc_hib: assert property (p_osc_hib) else $error("oscillator enable not pulled down");
	a_radio: assert property (p_radio) else $error("radio switch pad wrong");
	a_strap_hold: assert property (p_strap_hold) else $error("straps changed after boot");
	a_ana_low: assert property (p_ana_low) else $error("analog route on digital pad");
	a_ana_hiz: assert property (p_ana_hiz) else $error("analog pad also driven");
	c_err: cover property (pready && pslverr);
	c_hib: cover property (done && mode == 2'h2);
	c_ana: cover property (|pad_analog_en);
endmodule
bind pmx_top pmx_chk chk (.*);

// *** test/pmx_board.sv ***
`timescale 1ns/100ps
`include "pmx_map.svh"
module pmx_board #(
	parameter logic [5:0] BOARD_RES = 6'h0F,
	parameter logic [5:0] BOARD_LVL = 6'h0D
) (
	input  wire logic                     pclk,
	input  wire logic [`PMX_NUM_PADS-1:0] pad_out,
	input  wire logic [`PMX_NUM_PADS-1:0] pad_oe_n,
	input  wire logic [`PMX_NUM_PADS-1:0] pad_pull_up,
	input  wire logic [`PMX_NUM_PADS-1:0] pad_pull_down,
	output logic      [`PMX_NUM_PADS-1:0] pad_in
);
	logic float_bit = 1'b0;
	// an unpulled, undriven line wanders so a stale level is never read
	always @(posedge pclk) float_bit <= !float_bit;
	always_comb begin
		for (int i = 0; i < `PMX_NUM_PADS; i++) begin
			if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
			else if (BOARD_RES[i]) pad_in[i] = BOARD_LVL[i];
			else if (pad_pull_up[i] != pad_pull_down[i]) pad_in[i] = pad_pull_up[i];
			else pad_in[i] = float_bit ^ i[0];
		end
	end
endmodule

// *** test/pad_mux_low_power_states_tb_top.sv ***
`timescale 1ns/100ps
`include "pmx_map.svh"
module pad_mux_low_power_states_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        radio_sw_ctrl = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [95:0] func_out = {6{16'hAAAA}};
	logic [95:0] func_oe = {96{1'b1}};
	logic [31:0] prdata, rd;
	logic        pready, pslverr, slow_clk_ext, err;
	logic [5:0]  func_in, pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, pad_analog_en;
	logic [2:0]  boot_mode_strap;
	logic [3:0]  lp_exp [4] = '{4'h8, 4'hA, 4'h9, 4'h0};
	int          n_fail = 0;
	int          n_compared = 0;
	always #50 pclk = !pclk;
	always @(posedge pclk) radio_sw_ctrl <= !radio_sw_ctrl;
	pmx_top dut (.*);
	pmx_board board (.*);
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			$display("[FAIL] pready expected 1 seen 0");
			conclude;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pad controls packed as {oe_n, out, pull_up, pull_down}
	task automatic pad_chk(int p, logic [3:0] exp);
		repeat (3) @(posedge pclk);
		chk("pad", {28'h0, exp}, {28'h0, pad_oe_n[p], pad_out[p], pad_pull_up[p], pad_pull_down[p]});
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (103) @(posedge pclk);
		for (int p = 0; p < 6; p++) begin
			apb(1'b0, 12'(`PMX_PAD_CFG_BASE + 4 * p), 32'h0);
			chk("cfg reset", 32'h0, rd);
		end
		apb(1'b0, `PMX_STATUS_ADDR, 32'h0);
		chk("status", 32'h36, rd);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		// odd encodings carry a one, 14 and 15 must float
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, 12'h020, 32'(s));
			pad_chk(4, (s < 14) ? 4'(s % 2 * 4) : 4'h8);
		end
		apb(1'b1, 12'h024, 32'h80);
		pad_chk(5, 4'h8);
		chk("analog", 32'h20, {26'h0, pad_analog_en});
		for (int p = 3; p < 6; p++) apb(1'b1, 12'(`PMX_PAD_CFG_BASE + 4 * p), 32'h20);
		// select parked on a live function that would drive one
		for (int m = 1; m < 3; m++) begin
			for (int l = 0; l < 4; l++) begin
				apb(1'b1, 12'h020, 32'h01 | 32'(l) << 4);
				apb(1'b1, `PMX_CTRL_ADDR, 32'(m));
				pad_chk(4, lp_exp[l]);
			end
			// drive level must come from the override, function 0 would drive zero
			apb(1'b1, 12'h020, 32'h70);
			pad_chk(4, 4'h4);
		end
		pad_chk(0, 4'h9);
		apb(1'b1, 12'h020, 32'h31);
		apb(1'b1, `PMX_CTRL_ADDR, 32'h3);
		pad_chk(4, 4'h4);
		// two more edges let the driven level pass the pin synchroniser
		repeat (2) @(posedge pclk);
		chk("func_in", 32'h10, {26'h0, func_in});
		apb(1'b0, `PMX_PAD_IN_ADDR, 32'h0);
		chk("pad_in", 32'h11, rd & 32'h3D);
		apb(1'b0, `PMX_CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h3, rd);
		conclude;
	end
endmodule
